// File: shared/pin_io_consts.vh
`ifndef PIN_IO_CONSTS_VH
`define PIN_IO_CONSTS_VH

// register indices; byte address is four times the index
`define IDX_PORT_B_DATA 4'h1
`define IDX_PORT_C_DATA 4'h2
`define IDX_PORT_D_DATA 4'h3
`define IDX_PORT_E_DATA 4'h4
`define IDX_PORT_B_DIR  4'h5
`define IDX_PORT_C_DIR  4'h6
`define IDX_PORT_E_DIR  4'h7

`define ADDR_PORT_B_DATA 8'h04
`define ADDR_PORT_C_DATA 8'h08
`define ADDR_PORT_D_DATA 8'h0C
`define ADDR_PORT_E_DATA 8'h10
`define ADDR_PORT_B_DIR  8'h14
`define ADDR_PORT_C_DIR  8'h18
`define ADDR_PORT_E_DIR  8'h1C

`define DIR_RESET_8  8'h00
`define DIR_RESET_7  7'h00
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2

`endif

// File: rtl/four_port_pin_io.v
`timescale 1ns/1ps
`default_nettype none
`include "pin_io_consts.vh"

// Function
// RL1: port B is eight bidirectional pins, each with its own data latch
// RL2: port B data latches hold their contents through reset
// RL3: port B direction bit 1 drives the pin, 0 leaves it undriven
// RL4: reset clears all port B direction bits, making pins inputs
// RL5: port B read gives latch where direction is 1, pin where 0
// RL6: data writes always update latches; inputs still read the pin
// RL7: software loads the latch before turning a pin to output
// RL8: port C is seven bidirectional pins, each with its own latch
// RL9: reset clears the seven port C direction bits
// RL10: port C read gives latch where direction is 1, pin where 0
// RL11: port C data latches are unaffected by reset
// RL12: port D is seven input-only pins, no direction, no drivers
// RL13: port D read returns pin levels in bits 6..0, bit 7 zero
// RL14: port D writes go only to its latch, which reset leaves alone
// RL15: port E is eight pins with latches, shared with two timers
// RL16: timer-owned port E pins ignore direction, which still selects read source
// RL17: reset clears port E direction bits; direction 1 drives the pin
// RL18: port E read gives latch where direction is 1, pin where 0
// RL19: unimplemented bits of seven-bit registers read zero, ignore writes
module four_port_pin_io (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire [2:0]  s_axi_awprot,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire [2:0]  s_axi_arprot,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire [7:0]  port_b_pin_in,
	output reg  [7:0]  port_b_pin_out,
	output reg  [7:0]  port_b_pin_oe,
	input  wire [6:0]  port_c_pin_in,
	output reg  [6:0]  port_c_pin_out,
	output reg  [6:0]  port_c_pin_oe,
	input  wire [6:0]  port_d_pin_in,
	input  wire [7:0]  port_e_pin_in,
	output reg  [7:0]  port_e_pin_out,
	output reg  [7:0]  port_e_pin_oe,
	input  wire [7:0]  port_e_timer_owned,
	input  wire [7:0]  port_e_timer_out,
	input  wire [7:0]  port_e_timer_oe
);

	// latches: no reset term, so reset leaves them alone
	reg  [7:0]  port_b_latch_ff;
	reg  [6:0]  port_c_latch_ff;
	reg  [6:0]  port_d_latch_ff;
	reg  [7:0]  port_e_latch_ff;
	reg  [7:0]  port_b_direction_ff;
	reg  [6:0]  port_c_direction_ff;
	reg  [7:0]  port_e_direction_ff;

	reg  [7:0]  b_meta_ff;
	reg  [7:0]  b_sync_ff;
	reg  [6:0]  c_meta_ff;
	reg  [6:0]  c_sync_ff;
	reg  [6:0]  d_meta_ff;
	reg  [6:0]  d_sync_ff;
	reg  [7:0]  e_meta_ff;
	reg  [7:0]  e_sync_ff;
	reg  [7:0]  e_owned_meta_ff;
	reg  [7:0]  e_owned_sync_ff;

	reg  [7:0]  aw_addr_ff;
	reg         aw_held_ff;
	reg  [31:0] w_data_ff;
	reg  [3:0]  w_strb_ff;
	reg         w_held_ff;

	reg  [31:0] nxt_rdata;
	reg         nxt_rhit;

	wire        do_write;
	wire        wr_lane0;

	// latch where direction is 1, synchronised pin level where 0
	function [7:0] port_read;
		input [7:0] dir;
		input [7:0] latch;
		input [7:0] pin;
		begin
			port_read = (dir & latch) | (~dir & pin);
		end
	endfunction

	function wr_hit;
		input [7:0] addr;
		input [7:0] target;
		begin
			wr_hit = (addr[7:2] == target[7:2]);
		end
	endfunction

	// two-flop synchronisers for the four pin inputs and port_e_timer_owned; timer out and oe are used unsynchronised
	always @(posedge aclk) begin
		b_meta_ff       <= port_b_pin_in;
		b_sync_ff       <= b_meta_ff;
		c_meta_ff       <= port_c_pin_in;
		c_sync_ff       <= c_meta_ff;
		d_meta_ff       <= port_d_pin_in;
		d_sync_ff       <= d_meta_ff;
		e_meta_ff       <= port_e_pin_in;
		e_sync_ff       <= e_meta_ff;
		e_owned_meta_ff <= port_e_timer_owned;
		e_owned_sync_ff <= e_owned_meta_ff;
	end

	// write channel: address and data taken in either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_ff    <= 1'b0;
			w_held_ff     <= 1'b0;
			aw_addr_ff    <= 8'h00;
			w_data_ff     <= 32'h00000000;
			w_strb_ff     <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
		end else begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			if (s_axi_awvalid && !aw_held_ff && !s_axi_awready && !s_axi_bvalid) begin
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wvalid && !w_held_ff && !s_axi_wready && !s_axi_bvalid) begin
				s_axi_wready <= 1'b1;
			end
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_ff <= 1'b1;
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held_ff   <= 1'b0;
				w_held_ff    <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr_ff[7:2] >= `ADDR_PORT_B_DATA >> 2 &&
					aw_addr_ff[7:2] <= `ADDR_PORT_E_DIR >> 2) ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	assign do_write = aw_held_ff && w_held_ff && !s_axi_bvalid;
	assign wr_lane0 = do_write && w_strb_ff[0];

	// data latches: written whatever the direction, never reset
	always @(posedge aclk) begin
		if (wr_lane0 && wr_hit(aw_addr_ff, `ADDR_PORT_B_DATA))
			port_b_latch_ff <= w_data_ff[7:0]; // RL1 RL2 RL6
		if (wr_lane0 && wr_hit(aw_addr_ff, `ADDR_PORT_C_DATA))
			port_c_latch_ff <= w_data_ff[6:0]; // RL8 RL11 RL19
		if (wr_lane0 && wr_hit(aw_addr_ff, `ADDR_PORT_D_DATA))
			port_d_latch_ff <= w_data_ff[6:0]; // RL14
		if (wr_lane0 && wr_hit(aw_addr_ff, `ADDR_PORT_E_DATA))
			port_e_latch_ff <= w_data_ff[7:0]; // RL15 RL6
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			port_b_direction_ff <= `DIR_RESET_8; // RL4
			port_c_direction_ff <= `DIR_RESET_7; // RL9
			port_e_direction_ff <= `DIR_RESET_8; // RL17
		end else begin
			if (wr_lane0 && wr_hit(aw_addr_ff, `ADDR_PORT_B_DIR))
				port_b_direction_ff <= w_data_ff[7:0];
			if (wr_lane0 && wr_hit(aw_addr_ff, `ADDR_PORT_C_DIR))
				port_c_direction_ff <= w_data_ff[6:0]; // RL19
			if (wr_lane0 && wr_hit(aw_addr_ff, `ADDR_PORT_E_DIR))
				port_e_direction_ff <= w_data_ff[7:0];
		end
	end

	// pin drivers; port D has none
	always @(posedge aclk) begin
		if (!aresetn) begin
			port_b_pin_oe  <= 8'h00;
			port_c_pin_oe  <= 7'h00;
			port_e_pin_oe  <= 8'h00;
			port_b_pin_out <= 8'h00;
			port_c_pin_out <= 7'h00;
			port_e_pin_out <= 8'h00;
		end else begin
			port_b_pin_oe  <= port_b_direction_ff; // RL3
			port_b_pin_out <= port_b_latch_ff;
			port_c_pin_oe  <= port_c_direction_ff;
			port_c_pin_out <= port_c_latch_ff;
			port_e_pin_oe  <= (e_owned_sync_ff & port_e_timer_oe) |
				(~e_owned_sync_ff & port_e_direction_ff); // RL16 RL17
			port_e_pin_out <= (e_owned_sync_ff & port_e_timer_out) |
				(~e_owned_sync_ff & port_e_latch_ff); // RL16
		end
	end

	// read decode
	always @* begin
		nxt_rdata = 32'h00000000;
		nxt_rhit  = 1'b1;
		case ({2'b00, s_axi_araddr[7:2]})
			`ADDR_PORT_B_DATA >> 2:
				nxt_rdata[7:0] = port_read(port_b_direction_ff, port_b_latch_ff, b_sync_ff); // RL5
			`ADDR_PORT_C_DATA >> 2:
				nxt_rdata[7:0] = port_read({1'b0, port_c_direction_ff}, {1'b0, port_c_latch_ff},
					{1'b0, c_sync_ff}) & 8'h7F; // RL10 RL19
			`ADDR_PORT_D_DATA >> 2:
				nxt_rdata[6:0] = d_sync_ff; // RL12 RL13
			`ADDR_PORT_E_DATA >> 2:
				nxt_rdata[7:0] = port_read(port_e_direction_ff, port_e_latch_ff, e_sync_ff); // RL18 RL16
			`ADDR_PORT_B_DIR >> 2:
				nxt_rdata[7:0] = port_b_direction_ff;
			`ADDR_PORT_C_DIR >> 2:
				nxt_rdata[6:0] = port_c_direction_ff; // RL19
			`ADDR_PORT_E_DIR >> 2:
				nxt_rdata[7:0] = port_e_direction_ff;
			default:
				nxt_rhit = 1'b0;
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `RESP_OKAY;
		end else begin
			s_axi_arready <= 1'b0;
			if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= nxt_rdata;
				s_axi_rresp  <= nxt_rhit ? `RESP_OKAY : `RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule // four_port_pin_io

`default_nettype wire

// File: tb/pin_io_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "pin_io_consts.vh"
module pin_io_asserts (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic [7:0]  port_b_pin_oe,
	input wire logic [6:0]  port_c_pin_oe
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_rst_oe;
		$rose(aresetn) |-> port_b_pin_oe == 8'h00 && port_c_pin_oe == 7'h00;
	endproperty
	a_rst_oe: assert property (p_rst_oe) else $error("driver on after reset");
	property p_oe_cause;
		$changed(port_b_pin_oe) || $changed(port_c_pin_oe) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
	endproperty
	a_oe_cause: assert property (p_oe_cause) else $error("driver moved without write");
	property p_aw_pulse;
		s_axi_awready |=> !s_axi_awready;
	endproperty
	a_aw_pulse: assert property (p_aw_pulse) else $error("awready held");
	property p_r_lat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_r_lat: assert property (p_r_lat) else $error("read answer late");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	property p_hi0;
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
	endproperty
	a_hi0: assert property (p_hi0) else $error("upper read bits set");
	property p_b7;
		s_axi_arvalid && s_axi_arready && (s_axi_araddr == `ADDR_PORT_D_DATA || s_axi_araddr == `ADDR_PORT_C_DATA
			|| s_axi_araddr == `ADDR_PORT_C_DIR) |=> !s_axi_rdata[7];
	endproperty
	a_b7: assert property (p_b7) else $error("bit 7 set on seven-bit port");
	property p_slverr;
		s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h1C |=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0;
	endproperty
	a_slverr: assert property (p_slverr) else $error("unmapped read answered");
endmodule // pin_io_asserts
`default_nettype wire

// File: tb/pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module pin_model #(
	parameter int W = 8
) (
	input  wire logic [W-1:0] pin_out,
	input  wire logic [W-1:0] pin_oe,
	input  wire logic [W-1:0] ext,
	output logic      [W-1:0] pin_in
);
	// driven pins show the port's level, the rest the outside level
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule // pin_model
`default_nettype wire

// File: tb/four_port_pin_io_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "pin_io_consts.vh"
module four_port_pin_io_bench;
	logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, ext_b = 8'h00, ext_e = 8'h00;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [7:0] port_b_pin_in, port_b_pin_out, port_b_pin_oe, port_e_pin_in, port_e_pin_out, port_e_pin_oe;
	logic [6:0] port_c_pin_in, port_c_pin_out, port_c_pin_oe, port_d_pin_in = 7'h00, ext_c = 7'h00;
	logic [7:0] port_e_timer_owned = 8'h00, port_e_timer_out = 8'h00, port_e_timer_oe = 8'h00;
	int n_fail = 0, tests_run = 0, cyc = 0;
	four_port_pin_io dut_u (.*);
	pin_model #(.W(8)) pb_u (.pin_out(port_b_pin_out), .pin_oe(port_b_pin_oe), .ext(ext_b), .pin_in(port_b_pin_in));
	pin_model #(.W(7)) pc_u (.pin_out(port_c_pin_out), .pin_oe(port_c_pin_oe), .ext(ext_c), .pin_in(port_c_pin_in));
	pin_model #(.W(8)) pe_u (.pin_out(port_e_pin_out), .pin_oe(port_e_pin_oe), .ext(ext_e), .pin_in(port_e_pin_in));
	always #25 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			report_and_stop();
		end
	end
	task report_and_stop;
		$display("mismatches %0d of %0d checks", n_fail, tests_run);
		if (n_fail == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	function logic [1:0] ers(input logic [7:0] a);
		return (a[1:0] != 2'h0 || a < 8'h04 || a > 8'h1C) ? `RESP_SLVERR : `RESP_OKAY;
	endfunction
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk("bresp", {30'h0, ers(a)}, {30'h0, s_axi_bresp});
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e, input bit slow);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= !slow;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		// late rready makes the answer wait
		if (slow) begin
			repeat (3) @(posedge aclk);
			s_axi_rready <= 1'b1;
		end
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk("rdata", {24'h000000, e}, s_axi_rdata);
		chk("rresp", {30'h0, ers(a)}, {30'h0, s_axi_rresp});
	endtask
	task t_port_b;
		ext_b <= 8'hA5;
		wr(`ADDR_PORT_B_DATA, 8'h3C);
		rd(`ADDR_PORT_B_DATA, 8'hA5, 0);
		wr(`ADDR_PORT_B_DIR, 8'hF0);
		rd(`ADDR_PORT_B_DATA, 8'h35, 1);
		chk("b_oe", 8'hF0, port_b_pin_oe);
		chk("b_out", 8'h30, port_b_pin_out & 8'hF0);
	endtask
	task t_port_c;
		ext_c <= 7'h2A;
		wr(`ADDR_PORT_C_DATA, 8'h55);
		wr(`ADDR_PORT_C_DIR, 8'h8F);
		rd(`ADDR_PORT_C_DIR, 8'h0F, 0);
		rd(`ADDR_PORT_C_DATA, 8'h25, 1);
		wr(`ADDR_PORT_C_DATA, 8'hFF);
		rd(`ADDR_PORT_C_DATA, 8'h2F, 0);
		chk("c_out", 8'h7F, {1'b0, port_c_pin_out});
	endtask
	task t_port_d;
		port_d_pin_in <= 7'h5A;
		wr(`ADDR_PORT_D_DATA, 8'hFF);
		rd(`ADDR_PORT_D_DATA, 8'h5A, 0);
	endtask
	task t_port_e;
		ext_e <= 8'h33;
		port_e_timer_owned <= 8'hF0;
		port_e_timer_oe <= 8'hC0;
		port_e_timer_out <= 8'h40;
		wr(`ADDR_PORT_E_DATA, 8'h99);
		wr(`ADDR_PORT_E_DIR, 8'h0F);
		rd(`ADDR_PORT_E_DATA, 8'h79, 0);
		chk("e_oe", 8'hCF, port_e_pin_oe);
		chk("e_out", 8'h49, port_e_pin_out & 8'hCF);
		port_e_timer_owned <= 8'h00;
		wr(`ADDR_PORT_E_DIR, 8'h00);
		rd(`ADDR_PORT_E_DATA, 8'h33, 0);
		chk("e_oe", 8'h00, port_e_pin_oe);
	endtask
	task t_unmapped;
		wr(8'h40, 8'hFF);
		rd(8'h40, 8'h00, 0);
		rd(8'h00, 8'h00, 0);
		rd(`ADDR_PORT_B_DIR, 8'hF0, 0);
		// lane 0 strobe low: latch must keep its value
		s_axi_wstrb <= 4'hE;
		wr(`ADDR_PORT_B_DATA, 8'h00);
		s_axi_wstrb <= 4'hF;
		rd(`ADDR_PORT_B_DATA, 8'h35, 0);
	endtask
	task t_rst_keep;
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		chk("c_oe", 8'h00, port_c_pin_oe);
		rd(`ADDR_PORT_B_DIR, 8'h00, 0);
		rd(`ADDR_PORT_E_DIR, 8'h00, 1);
		wr(`ADDR_PORT_B_DIR, 8'hFF);
		rd(`ADDR_PORT_B_DATA, 8'h3C, 0);
		wr(`ADDR_PORT_C_DIR, 8'h7F);
		rd(`ADDR_PORT_C_DATA, 8'h7F, 0);
	endtask
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		chk("b_oe", 8'h00, port_b_pin_oe);
		rd(`ADDR_PORT_C_DIR, 8'h00, 0);
		t_port_b();
		t_port_c();
		t_port_d();
		t_port_e();
		t_unmapped();
		t_rst_keep();
		report_and_stop();
	end
endmodule // four_port_pin_io_bench
bind four_port_pin_io pin_io_asserts chk_u (.aclk, .aresetn, .s_axi_awready, .s_axi_bvalid, .s_axi_arvalid,
	.s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .port_b_pin_oe,
	.port_c_pin_oe);
`default_nettype wire
